/* dv/isa_top_props.sv */
module isa_top_props (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [8:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        boot_finish,
    input wire logic        crystal_valid_latched,
    input wire logic        crystal_valid_enable,
    input wire logic [2:0]  input_valid_latched,
    input wire logic [2:0]  input_valid_enable,
    input wire logic [29:0] output_latched,
    input wire logic [29:0] output_enable,
    input wire logic        irq_flag,
    input wire logic        boot_done
);
    import isa_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [9:0] out_any;
    logic [7:0] out_low;
    logic [1:0] out_high;
    logic [3:0] in_any;
    logic       rd_top;
    always_comb begin
        for (int k = 0; k < 10; k++) begin
            out_any[k] = |(output_latched[3*k+:3] & output_enable[3*k+:3]);
        end
    end
    assign out_low  = out_any[7:0];
    assign out_high = out_any[9:8];
    assign in_any   = {crystal_valid_latched & crystal_valid_enable,
                       input_valid_latched & input_valid_enable};
    assign rd_top   = reg_rd && reg_addr == TOP_STATUS_ADDR;
    a_reset_clears_outputs: assert property (
        $fell(reset) |-> !boot_done && !irq_flag && reg_rdata == REG_RESET)
        else $error("outputs not clear after reset");
    a_boot_done_sets: assert property (boot_finish |=> boot_done)
        else $error("boot done did not set");
    a_boot_done_holds: assert property (boot_done |=> boot_done)
        else $error("boot done dropped");
    a_input_sum_value: assert property (
        reg_rd && reg_addr == INPUT_SUM_ADDR |=> reg_rdata == {4'h0, $past(in_any)})
        else $error("input summary wrong");
    a_out_low_value: assert property (
        reg_rd && reg_addr == OUTPUT_SUM_L_ADDR |=> reg_rdata == $past(out_low))
        else $error("low output summary wrong");
    a_out_high_value: assert property (
        reg_rd && reg_addr == OUTPUT_SUM_H_ADDR |=> reg_rdata == {6'h00, $past(out_high)})
        else $error("high output summary wrong");
    a_top_out_bit: assert property (
        rd_top |=> reg_rdata[TOP_OUT_BIT] == |$past(out_low))
        else $error("top output bit wrong");
    a_top_in_bit: assert property (
        rd_top |=> reg_rdata[TOP_IN_BIT] == |$past(in_any))
        else $error("top input bit wrong");
    c_boot_done: cover property (boot_finish ##1 boot_done);
    c_flag_rise: cover property ($rose(irq_flag));
    c_loop_seen: cover property (rd_top ##1 reg_rdata[TOP_LOOP_BIT]);
endmodule

bind isa_top isa_top_props u_isa_top_props (
    .mclk, .reset, .reg_addr, .reg_rd, .reg_rdata, .boot_finish, .crystal_valid_latched,
    .crystal_valid_enable, .input_valid_latched, .input_valid_enable, .output_latched,
    .output_enable, .irq_flag, .boot_done
);

/* dv/tb_interrupt_status_aggregator.sv */
module tb_interrupt_status_aggregator;
    timeunit 1ns;
    timeprecision 1ps;
    import isa_pkg::*;
    logic        mclk                  = 1'h0;
    logic        reset                 = 1'h1;
    logic [8:0]  reg_addr              = 9'h000;
    logic        reg_wr                = 1'h0;
    logic        reg_rd                = 1'h0;
    logic [7:0]  reg_wdata             = 8'h00;
    logic [7:0]  reg_rdata;
    logic [3:0]  pin_level             = 4'h0;
    logic        boot_busy             = 1'h0;
    logic        boot_finish           = 1'h0;
    logic        crystal_valid_latched = 1'h0;
    logic        crystal_valid_enable  = 1'h0;
    logic [2:0]  input_valid_latched   = 3'h0;
    logic [2:0]  input_valid_enable    = 3'h0;
    logic [29:0] output_latched        = 30'h0;
    logic [29:0] output_enable         = 30'h0;
    logic [2:0]  loop_level            = 3'h0;
    logic        irq_flag;
    logic        boot_done;
    int          fail_count            = 0;
    int          tests_run             = 0;
    always #2 mclk = ~mclk;
    isa_top u_isa_top (
        .mclk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pin_level,
        .boot_busy, .boot_finish, .crystal_valid_latched, .crystal_valid_enable,
        .input_valid_latched, .input_valid_enable, .output_latched, .output_enable,
        .loop_freq_low(loop_level[2]), .loop_freq_high(loop_level[1]),
        .loop_lock(loop_level[0]), .irq_flag, .boot_done
    );
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'h1;
        @(negedge mclk);
        reg_wr = 1'h0;
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'h1;
        @(negedge mclk);
        reg_rd = 1'h0;
        check_reg(reg_rdata, exp);
    endtask
    // Polls the flag for a few cycles and ends the run if it never arrives.
    task automatic wait_flag(input logic exp);
        int n;
        n = 0;
        while (irq_flag !== exp && n < 8) begin
            @(negedge mclk);
            n++;
        end
        check_pin(irq_flag, exp);
        if (irq_flag !== exp) begin
            complete_run();
        end
    endtask
    task automatic loop_step(input logic [2:0] v, input logic [7:0] clr, input logic [7:0] exp);
        loop_level = v;
        repeat (5) @(negedge mclk);
        rd_chk(LOOP_STATUS_ADDR, exp);
        wr(LOOP_STATUS_ADDR, clr);
    endtask
    initial begin
        logic [15:0] e;
        repeat (10) @(negedge mclk);
        reset = 1'h0;
        for (int a = 9'h041; a <= 9'h04A; a++) begin
            rd_chk(9'(a), 8'h00);
        end
        boot_busy = 1'h1;
        wr(GLOBAL_FUNC_ADDR, 8'h08);
        rd_chk(GLOBAL_FUNC_ADDR, 8'h00);
        check_pin(boot_done, 1'h0);
        boot_finish = 1'h1;
        boot_busy   = 1'h0;
        @(negedge mclk);
        boot_finish = 1'h0;
        @(negedge mclk);
        check_pin(boot_done, 1'h1);
        wr(GLOBAL_FUNC_ADDR, 8'h08);
        rd_chk(GLOBAL_FUNC_ADDR, 8'h88);
        pin_level = 4'h3;
        repeat (5) @(negedge mclk);
        rd_chk(PIN_STATUS_ADDR, 8'h33);
        wait_flag(1'h0);
        wr(GLOBAL_FUNC_ADDR, 8'h03);
        wait_flag(1'h1);
        wr(PIN_STATUS_ADDR, 8'h30);
        rd_chk(PIN_STATUS_ADDR, 8'h03);
        wait_flag(1'h0);
        pin_level = 4'h0;
        repeat (5) @(negedge mclk);
        rd_chk(PIN_STATUS_ADDR, 8'h30);
        wr(PIN_STATUS_ADDR, 8'h30);
        wr(GLOBAL_FUNC_ADDR, 8'h00);
        for (int k = 0; k < 10; k++) begin
            e = 16'h0001 << k;
            output_latched = 30'h0;
            output_enable  = 30'h0;
            output_latched[3*k+k%3] = 1'h1;
            output_enable[3*k+k%3]  = 1'h1;
            rd_chk(OUTPUT_SUM_L_ADDR, e[7:0]);
            rd_chk(OUTPUT_SUM_H_ADDR, e[15:8]);
            rd_chk(TOP_STATUS_ADDR, {2'h0, |e[7:0], 5'h00});
        end
        output_latched = 30'h1;
        output_enable  = 30'h2;
        rd_chk(OUTPUT_SUM_L_ADDR, 8'h00);
        output_latched = 30'h0;
        input_valid_enable = 3'h7;
        for (int i = 0; i < 3; i++) begin
            input_valid_latched = 3'(1 << i);
            rd_chk(INPUT_SUM_ADDR, 8'(1 << i));
        end
        input_valid_latched   = 3'h0;
        crystal_valid_latched = 1'h1;
        rd_chk(INPUT_SUM_ADDR, 8'h00);
        crystal_valid_enable = 1'h1;
        rd_chk(INPUT_SUM_ADDR, 8'h08);
        wait_flag(1'h0);
        wr(TOP_STATUS_ADDR, 8'h02);
        wait_flag(1'h1);
        rd_chk(TOP_STATUS_ADDR, 8'h13);
        crystal_valid_enable = 1'h0;
        wait_flag(1'h0);
        wr(LOOP_ENABLE_ADDR, 8'hA8);
        loop_step(3'h4, 8'h00, 8'hC0);
        rd_chk(LOOP_SUM_ADDR, 8'h01);
        rd_chk(TOP_STATUS_ADDR, 8'h07);
        wait_flag(1'h1);
        loop_step(3'h0, 8'h80, 8'h80);
        loop_step(3'h2, 8'h00, 8'h30);
        loop_step(3'h0, 8'h20, 8'h20);
        loop_step(3'h1, 8'h08, 8'h0C);
        loop_step(3'h0, 8'h08, 8'h08);
        rd_chk(LOOP_STATUS_ADDR, 8'h00);
        wait_flag(1'h0);
        wr(LOOP_ENABLE_ADDR, 8'h00);
        loop_step(3'h4, 8'h00, 8'hC0);
        rd_chk(LOOP_SUM_ADDR, 8'h00);
        wait_flag(1'h0);
        complete_run();
    end
endmodule

/* src/isa_change_latch.sv */
module isa_change_latch #(
    parameter int unsigned WIDTH     = 1,
    parameter bit          BOTH_EDGE = 1'b1
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] clear_mask,
    output logic      [WIDTH-1:0] latched
);

    logic [WIDTH-1:0] prev;
    logic             primed;
    logic [WIDTH-1:0] event_hit;

    // No event is taken in the first cycle after reset, so a level that is
    // already high at release does not look like a change.
    assign event_hit = primed ? (BOTH_EDGE ? (level ^ prev) : (level & ~prev)) : '0;

    always_ff @(posedge mclk) begin
        if (reset) begin
            prev   <= '0;
            primed <= 1'b0;
        end else begin
            prev   <= level;
            primed <= 1'b1;
        end
    end

    // A new event in the clearing cycle keeps the bit set.
    always_ff @(posedge mclk) begin
        if (reset) begin
            latched <= '0;
        end else begin
            latched <= event_hit | (latched & ~clear_mask);
        end
    end

endmodule

/* src/isa_pkg.sv */
// What this block does
// - Pins 3..0 raw levels readable, no inversion.
// - Top bit 5 = any low output summary (outputs 7..0).
// - Top bit 4 = any input summary.
// - Top bit 2 = loop summary.
// - Top bit 1 enables summary bits globally.
// - Flag bit 0 = enable and any of top bits 5, 4, 2.
// - Enabled latched pin change also sets flag.
// - Flag leaves as a pin level and reads back as top bit 0.
// - Boot-done clears on reset, sets at finish.
// - Host watches pin for boot-done during boot.
// - Host writes ignored while boot runs.
// - Global bits 3..0 enable pin changes.
// - Input summary bit 3 = crystal latched and enabled.
// - Input summary bits 2..0 per clock input.
// - Output summaries: any enabled latched output bit.
// - Loop summary = any enabled latched loop bit.
// - Low-frequency latch sets on rise, write-1 clears.
// - Bit 6 shows frequency below expected.
// - High-frequency latch sets on rise, write-1 clears.
// - Bit 4 shows frequency above expected.
// - Pin change latches either edge, write-1 clears.
// - Lock change latch on any lock change.
// - Loop enable register gates three latched bits.
package isa_pkg;

    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] PIN_STATUS_ADDR   = 9'h041;
    localparam logic [ADDR_W-1:0] TOP_STATUS_ADDR   = 9'h042;
    localparam logic [ADDR_W-1:0] GLOBAL_FUNC_ADDR  = 9'h043;
    localparam logic [ADDR_W-1:0] INPUT_SUM_ADDR    = 9'h044;
    localparam logic [ADDR_W-1:0] OUTPUT_SUM_L_ADDR = 9'h045;
    localparam logic [ADDR_W-1:0] OUTPUT_SUM_H_ADDR = 9'h046;
    localparam logic [ADDR_W-1:0] LOOP_SUM_ADDR     = 9'h047;
    localparam logic [ADDR_W-1:0] LOOP_STATUS_ADDR  = 9'h048;
    localparam logic [ADDR_W-1:0] LOOP_ENABLE_ADDR  = 9'h04A;

    localparam int unsigned TOP_OUT_BIT    = 5;
    localparam int unsigned TOP_IN_BIT     = 4;
    localparam int unsigned TOP_LOOP_BIT   = 2;
    localparam int unsigned TOP_IE_BIT     = 1;
    localparam int unsigned TOP_FLAG_BIT   = 0;
    localparam int unsigned BOOT_DONE_BIT  = 7;
    localparam int unsigned PIN_LATCH_LSB  = 4;
    localparam int unsigned CRYSTAL_BIT    = 3;
    localparam int unsigned FREQ_LOW_L_BIT = 7;
    localparam int unsigned FREQ_LOW_BIT   = 6;
    localparam int unsigned FREQ_HI_L_BIT  = 5;
    localparam int unsigned FREQ_HI_BIT    = 4;
    localparam int unsigned LOCK_L_BIT     = 3;
    localparam int unsigned LOCK_BIT       = 2;

    localparam int unsigned PIN_COUNT      = 4;
    localparam int unsigned CLK_IN_COUNT   = 3;
    localparam int unsigned OUT_COUNT      = 10;
    localparam int unsigned OUT_SRC_COUNT  = 3;
    localparam int unsigned OUT_LOW_COUNT  = 8;

    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

endpackage

/* src/isa_sync2.sv */
module isa_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* src/isa_top.sv */
module isa_top (
    input  wire logic                          mclk,
    input  wire logic                          reset,
    input  wire logic [isa_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [isa_pkg::DATA_W-1:0]    reg_wdata,
    output logic      [isa_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic [isa_pkg::PIN_COUNT-1:0] pin_level,
    input  wire logic                          boot_busy,
    input  wire logic                          boot_finish,
    input  wire logic                          crystal_valid_latched,
    input  wire logic                          crystal_valid_enable,
    input  wire logic [isa_pkg::CLK_IN_COUNT-1:0] input_valid_latched,
    input  wire logic [isa_pkg::CLK_IN_COUNT-1:0] input_valid_enable,
    input  wire logic [isa_pkg::OUT_COUNT*isa_pkg::OUT_SRC_COUNT-1:0] output_latched,
    input  wire logic [isa_pkg::OUT_COUNT*isa_pkg::OUT_SRC_COUNT-1:0] output_enable,
    input  wire logic                          loop_freq_low,
    input  wire logic                          loop_freq_high,
    input  wire logic                          loop_lock,
    output logic                               irq_flag,
    output logic                               boot_done
);

    import isa_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Signals.

    logic [PIN_COUNT-1:0]    pin_sync;
    logic [2:0]              loop_sync;
    logic [PIN_COUNT-1:0]    pin_clear;
    logic [PIN_COUNT-1:0]    pin_change_latched;
    logic [2:0]              loop_clear;
    logic [1:0]              loop_rise_latched;
    logic [0:0]              loop_lock_change_latched;
    logic                    global_irq_enable;
    logic [PIN_COUNT-1:0]    pin_change_enable;
    logic                    loop_freq_low_enable;
    logic                    loop_freq_high_enable;
    logic                    loop_lock_change_enable;
    logic [CLK_IN_COUNT:0]   inputs_irq_summary;
    logic [OUT_COUNT-1:0]    outputs_irq_summary;
    logic                    loop_irq_summary;
    logic                    host_write;
    logic                    next_irq_flag;

    ////////////////////////////////////////////////////////////////////////////
    // Pin and loop status inputs come from other domains.

    isa_sync2 #(
        .WIDTH (PIN_COUNT)
    ) u_pin_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (pin_level),
        .sync_out (pin_sync)
    );

    isa_sync2 #(
        .WIDTH (3)
    ) u_loop_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in ({loop_freq_low, loop_freq_high, loop_lock}),
        .sync_out (loop_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Host write qualification and write-one-to-clear masks.

    assign host_write = reg_wr && !boot_busy;

    assign pin_clear = (host_write && reg_addr == PIN_STATUS_ADDR) ?
                       reg_wdata[PIN_LATCH_LSB +: PIN_COUNT] : '0;

    assign loop_clear = (host_write && reg_addr == LOOP_STATUS_ADDR) ?
                        {reg_wdata[FREQ_LOW_L_BIT], reg_wdata[FREQ_HI_L_BIT],
                         reg_wdata[LOCK_L_BIT]} : 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Latched status bits.

    isa_change_latch #(
        .WIDTH     (PIN_COUNT),
        .BOTH_EDGE (1'b1)
    ) u_pin_latch (
        .mclk       (mclk),
        .reset      (reset),
        .level      (pin_sync),
        .clear_mask (pin_clear),
        .latched    (pin_change_latched)
    );

    isa_change_latch #(
        .WIDTH     (2),
        .BOTH_EDGE (1'b0)
    ) u_freq_latch (
        .mclk       (mclk),
        .reset      (reset),
        .level      (loop_sync[2:1]),
        .clear_mask (loop_clear[2:1]),
        .latched    (loop_rise_latched)
    );

    isa_change_latch #(
        .WIDTH     (1),
        .BOTH_EDGE (1'b1)
    ) u_lock_latch (
        .mclk       (mclk),
        .reset      (reset),
        .level      (loop_sync[0:0]),
        .clear_mask (loop_clear[0:0]),
        .latched    (loop_lock_change_latched)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Writable enables.

    always_ff @(posedge mclk) begin
        if (reset) begin
            global_irq_enable <= 1'b0;
        end else if (host_write && reg_addr == TOP_STATUS_ADDR) begin
            global_irq_enable <= reg_wdata[TOP_IE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_change_enable <= '0;
        end else if (host_write && reg_addr == GLOBAL_FUNC_ADDR) begin
            pin_change_enable <= reg_wdata[PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            loop_freq_low_enable    <= 1'b0;
            loop_freq_high_enable   <= 1'b0;
            loop_lock_change_enable <= 1'b0;
        end else if (host_write && reg_addr == LOOP_ENABLE_ADDR) begin
            loop_freq_low_enable    <= reg_wdata[FREQ_LOW_L_BIT];
            loop_freq_high_enable   <= reg_wdata[FREQ_HI_L_BIT];
            loop_lock_change_enable <= reg_wdata[LOCK_L_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boot completion flag.

    always_ff @(posedge mclk) begin
        if (reset) begin
            boot_done <= 1'b0;
        end else if (boot_finish) begin
            boot_done <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summaries, derived continuously.

    assign inputs_irq_summary[CRYSTAL_BIT] = crystal_valid_latched && crystal_valid_enable;
    assign inputs_irq_summary[CLK_IN_COUNT-1:0] = input_valid_latched & input_valid_enable;

    for (genvar k = 0; k < OUT_COUNT; k++) begin : g_out_sum
        assign outputs_irq_summary[k] =
            |(output_latched[k*OUT_SRC_COUNT +: OUT_SRC_COUNT] &
              output_enable[k*OUT_SRC_COUNT +: OUT_SRC_COUNT]);
    end

    assign loop_irq_summary = (loop_rise_latched[1] && loop_freq_low_enable) ||
                              (loop_rise_latched[0] && loop_freq_high_enable) ||
                              (loop_lock_change_latched[0] && loop_lock_change_enable);

    function automatic logic [DATA_W-1:0] top_status_value(input logic ie);
        logic [DATA_W-1:0] v;
        v = REG_RESET;
        v[TOP_OUT_BIT]  = |outputs_irq_summary[OUT_LOW_COUNT-1:0];
        v[TOP_IN_BIT]   = |inputs_irq_summary;
        v[TOP_LOOP_BIT] = loop_irq_summary;
        v[TOP_IE_BIT]   = ie;
        return v;
    endfunction

    assign next_irq_flag =
        (global_irq_enable &&
         (|outputs_irq_summary[OUT_LOW_COUNT-1:0] || |inputs_irq_summary ||
          loop_irq_summary)) ||
        |(pin_change_latched & pin_change_enable);

    // The flag is offered to the pin multiplexer as a registered level.
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_flag <= 1'b0;
        end else begin
            irq_flag <= next_irq_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read path; unmapped offsets read zero.

    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= REG_RESET;
        end else if (reg_rd) begin
            case (reg_addr)
                PIN_STATUS_ADDR: begin
                    reg_rdata <= {pin_change_latched, pin_sync};
                end
                TOP_STATUS_ADDR: begin
                    reg_rdata <= top_status_value(global_irq_enable) |
                                 {{(DATA_W-1){1'b0}}, next_irq_flag};
                end
                GLOBAL_FUNC_ADDR: begin
                    reg_rdata <= {boot_done, 3'h0, pin_change_enable};
                end
                INPUT_SUM_ADDR: begin
                    reg_rdata <= {4'h0, inputs_irq_summary};
                end
                OUTPUT_SUM_L_ADDR: begin
                    reg_rdata <= outputs_irq_summary[OUT_LOW_COUNT-1:0];
                end
                OUTPUT_SUM_H_ADDR: begin
                    reg_rdata <= {6'h00, outputs_irq_summary[OUT_COUNT-1:OUT_LOW_COUNT]};
                end
                LOOP_SUM_ADDR: begin
                    reg_rdata <= {7'h00, loop_irq_summary};
                end
                LOOP_STATUS_ADDR: begin
                    reg_rdata <= {loop_rise_latched[1], loop_sync[2],
                                  loop_rise_latched[0], loop_sync[1],
                                  loop_lock_change_latched[0], loop_sync[0],
                                  2'h0};
                end
                LOOP_ENABLE_ADDR: begin
                    reg_rdata <= {loop_freq_low_enable, 1'b0, loop_freq_high_enable, 1'b0,
                                  loop_lock_change_enable, 3'h0};
                end
                default: begin
                    reg_rdata <= REG_RESET;
                end
            endcase
        end
    end

endmodule
